// [pgc_dut_model.sv]
/*
 * Behavioural device under test facing the pattern block channels.
 * Assumes one system clock; released lines carry the bench's answer.
 */
`timescale 1ns/1ps
module pgc_dut_model #(
    parameter int CH = 20
) (
    // Clock
    input wire logic clk_i,
    // Channels from the block
    input wire logic [CH-1:0] data_i,
    input wire logic [CH-1:0] oe_n_i,
    // Answer on released lines
    input wire logic [CH-1:0] resp_i,
    // Lines seen by acquisition
    output logic [CH-1:0] acq_o
);
    // Driven lines read back, released lines show own answer
    wire logic [CH-1:0] nxt_acq = (data_i & ~oe_n_i) | (resp_i & oe_n_i);

    // One cycle of line delay, so the answer is not instant
    always_ff @(posedge clk_i) begin
        acq_o <= nxt_acq;
    end
endmodule

// [pgc_pkg.sv]
/*
 * Package for the pattern generation and compare block: register offsets,
 * field positions, enumerations and timing constants.
 * Assumes a 100 MHz system clock and a plain strobe register port.
 */
package pgc_pkg;
    // System clock period in picoseconds
    localparam int CLK_PERIOD_PS = 10000;
    // Exported clock offset choice, printed figure in picoseconds
    localparam int CLK_OFFSET_PS = 2500;
    // Offset in fine delay steps (steps of period / 256), rounded down
    localparam int CLK_OFFSET_STEPS = (CLK_OFFSET_PS * 256) / CLK_PERIOD_PS;
    // Delay fraction width: value of 256 means one full period
    localparam int DLY_W = 9;
    localparam logic [DLY_W-1:0] DLY_FULL = 9'h100;

    // Register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DATA_DLY = 8'h08;
    localparam logic [7:0] REG_CLK_DLY = 8'h0C;
    localparam logic [7:0] REG_POS_RISE = 8'h10;
    localparam logic [7:0] REG_POS_FALL = 8'h14;
    localparam logic [7:0] REG_START_CFG = 8'h18;
    localparam logic [7:0] REG_PAUSE_CFG = 8'h1C;
    localparam logic [7:0] REG_SCRIPT_CFG = 8'h20;
    localparam logic [7:0] REG_ROUTE = 8'h24;
    localparam logic [7:0] REG_TRI_ADDR = 8'h28;
    localparam logic [7:0] REG_TRI_DATA = 8'h2C;
    localparam logic [7:0] REG_FLT_INDEX = 8'h30;
    localparam logic [7:0] REG_FLT_MASK = 8'h34;
    localparam logic [7:0] REG_FLT_COUNT = 8'h38;
    localparam logic [7:0] REG_SAMPLE_CNT = 8'h3C;

    // Control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_SW_START = 1;
    localparam int CTRL_SW_PAUSE = 2;
    localparam int CTRL_CMP_MODE = 3;
    localparam int CTRL_FILTER = 4;
    localparam int CTRL_CLK_OFS = 5;
    localparam int CTRL_SW_SCRIPT = 8;
    // Status register fields
    localparam int STAT_READY = 0;
    localparam int STAT_ACTIVE = 1;
    localparam int STAT_FAULT = 2;
    // Trigger source select: 0..3 pins, 4..11 chassis lines, 12 software
    localparam int SRC_W = 4;
    localparam logic [SRC_W-1:0] SRC_SW = 4'hC;
    // Routing destination code: 0..3 pins, 4..10 chassis lines, 15 none
    localparam logic [SRC_W-1:0] DST_NONE = 4'hF;
    localparam logic [SRC_W-1:0] DST_LINE0 = 4'h4;

    // Tristate memory depth
    localparam int TRI_DEPTH = 4095;
    localparam int TRI_AW = 12;

    // Per-sample logic states carried by the waveform data type
    typedef enum logic [2:0] {
        LS_DRIVE_LO = 3'b000,
        LS_DRIVE_HI = 3'b001,
        LS_TRI = 3'b010,
        LS_EXP_LO = 3'b011,
        LS_EXP_HI = 3'b100,
        LS_IGNORE = 3'b101
    } pgc_lstate_t;

    // Generation engine states
    typedef enum logic [1:0] {
        GS_IDLE = 2'b00,
        GS_READY = 2'b01,
        GS_ACTIVE = 2'b10,
        GS_PAUSED = 2'b11
    } pgc_gen_t;
endpackage

// [pgc_top.sv]
/*
 * Pattern generation output stage with hardware response comparison.
 * Assumes the pattern engine feeds one sample per cycle on the sample
 * stream ports, and that triggers and acquired data come from pins.
 */
`timescale 1ns/1ps
// Overview of operation
// - Data delay programmable from zero to one period
// - Per channel rising, falling or delayed position
// - One shared delay for all delayed channels
// - Exported clock offset zero or 2.5 ns
// - Exported clock delay independent of data delay
// - Triggers synchronised, may take several cycles
// - Ready, active, marker events track data
// - Start edge from pins, lines or software
// - Pause level suspends generation
// - Four script triggers, edge or level
// - Route triggers and events; active pins only
// - Three marker events (0 to 2) routable as outputs
// - Per sample drive low, high or release
// - Tristate patterns in separate deduplicated memory
// - Tristate memory holds 4095 combinations
// - Expected states compared against acquired response
// - Stimulus-and-expected or expected-only mode
// - Decoder drives enables, passes expected values
// - Expected values delayed to align with acquisition
// - Fault record holds index and channel mask
// - Repeat counter, optional collapse of repeats
// - Sample error event on any mismatch
module pgc_top import pgc_pkg::*; #(
    parameter int CH = 20,
    parameter int ALIGN = 4
) (
    // Clock, reset, enable
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire logic CE_I,
    // Register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    // Sample stream from the pattern engine
    input wire logic SMP_VALID_I,
    output logic SMP_READY_O,
    input wire logic [3*CH-1:0] SMP_STATE_I,
    input wire logic [TRI_AW-1:0] SMP_TRI_IDX_I,
    input wire logic [3:0] SMP_MARKER_I,
    // Trigger pins
    input wire logic [3:0] FUNCTION_PIN_I,
    input wire logic [7:0] CHASSIS_TRIGGER_LINE_I,
    // Event outputs with active-low enables
    output logic [3:0] FUNCTION_PIN_O,
    output logic [3:0] FUNCTION_PIN_OE_N_O,
    output logic [6:0] CHASSIS_TRIGGER_LINE_O,
    output logic [6:0] CHASSIS_TRIGGER_LINE_OE_N_O,
    // Channels toward the device under test
    output logic [CH-1:0] DATA_O,
    output logic [CH-1:0] DATA_OE_N_O,
    output logic [CH-1:0] DATA_LATE_O,
    output logic [DLY_W-1:0] DATA_DLY_O,
    input wire logic [CH-1:0] ACQ_DATA_I,
    // Exported clock timing
    output logic [DLY_W-1:0] CLK_DLY_O,
    output logic CLK_OFS_O,
    // Events
    output logic READY_O,
    output logic ACTIVE_O,
    output logic [3:0] MARKER_O,
    output logic SAMPLE_ERR_O
);
    // Configuration registers
    logic [31:0] ctrl_ff;
    logic [DLY_W-1:0] data_dly_ff, clk_dly_ff;
    logic [CH-1:0] pos_rise_ff, pos_fall_ff;
    logic [5:0] start_cfg_ff; // Source in low bits, edge select bit 4
    logic [SRC_W-1:0] pause_src_ff;
    logic [31:0] script_cfg_ff; // Four bytes: source, level bit 4
    logic [31:0] route_ff; // Nibbles: start pause scr0 ready act mk0..mk2
    logic [TRI_AW-1:0] tri_addr_ff;
    logic [CH-1:0] tri_mem [TRI_DEPTH]; // Tristate combinations
    // Engine and compare state
    pgc_gen_t gen_ff;
    logic [31:0] smp_cnt_ff;
    logic [31:0] flt_idx_ff, flt_cnt_ff;
    logic [CH-1:0] flt_mask_ff;
    logic flt_any_ff;
    logic [CH-1:0] exp_val_ff [ALIGN]; // Alignment line
    logic [CH-1:0] exp_en_ff [ALIGN];
    logic [31:0] exp_idx_ff [ALIGN];
    logic [11:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
    logic [CH-1:0] acq_s1_ff, acq_s2_ff;
    logic [3:0] scr_prev_ff, scr_hit_ff;

    // Trigger inputs: two flops then an edge register
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_s3_ff <= '0;
            acq_s1_ff <= '0;
            acq_s2_ff <= '0;
        end else if (CE_I) begin
            pin_s1_ff <= {CHASSIS_TRIGGER_LINE_I, FUNCTION_PIN_I};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            acq_s1_ff <= ACQ_DATA_I;
            acq_s2_ff <= acq_s1_ff;
        end
    end

    // Source selection helpers
    wire [15:0] lvl_vec = {3'h0, ctrl_ff[CTRL_SW_START], pin_s2_ff};
    wire [15:0] prv_vec = {3'h0, 1'b0, pin_s3_ff};
    wire [SRC_W-1:0] st_src = start_cfg_ff[SRC_W-1:0];
    wire st_fall = start_cfg_ff[4];
    // Start edge; software start counts as a pulse
    wire st_now = lvl_vec[st_src];
    wire st_old = prv_vec[st_src];
    wire start_hit = (st_src == SRC_SW) ? ctrl_ff[CTRL_SW_START] :
                     (st_fall ? (st_old & ~st_now) : (st_now & ~st_old));
    // Pause level from pin, line or software
    wire [15:0] pz_vec = {3'h0, ctrl_ff[CTRL_SW_PAUSE], pin_s2_ff};
    wire pause_lvl = pz_vec[pause_src_ff];

    // Script triggers, each edge or level
    logic [3:0] scr_lvl, scr_trig;
    for (genvar g = 0; g < 4; g++) begin : g_scr
        wire [SRC_W-1:0] s_src = script_cfg_ff[8*g +: SRC_W];
        wire [15:0] s_vec = {3'h0, ctrl_ff[CTRL_SW_SCRIPT+g], pin_s2_ff};
        assign scr_lvl[g] = s_vec[s_src];
        assign scr_trig[g] = script_cfg_ff[8*g+4] ? scr_lvl[g]
                                                  : (scr_lvl[g] & ~scr_prev_ff[g]);
    end

    // Generation state machine
    wire smp_take = (gen_ff == GS_ACTIVE) & SMP_VALID_I;
    assign SMP_READY_O = (gen_ff == GS_ACTIVE);
    pgc_gen_t nxt_gen;
    always_comb begin
        nxt_gen = gen_ff;
        case (gen_ff)
            GS_IDLE: if (ctrl_ff[CTRL_RUN]) nxt_gen = GS_READY;
            GS_READY: if (start_hit) nxt_gen = GS_ACTIVE;
            GS_ACTIVE: if (!ctrl_ff[CTRL_RUN]) nxt_gen = GS_IDLE;
                       else if (pause_lvl) nxt_gen = GS_PAUSED;
            GS_PAUSED: if (!ctrl_ff[CTRL_RUN]) nxt_gen = GS_IDLE;
                       else if (!pause_lvl) nxt_gen = GS_ACTIVE;
            default: nxt_gen = GS_IDLE;
        endcase
    end

    // Decoder: per channel drive value, release and expectations
    logic [CH-1:0] dec_val, dec_rel, dec_exp, dec_chk;
    wire [CH-1:0] tri_pat = tri_mem[SMP_TRI_IDX_I]; // Shared pattern
    for (genvar c = 0; c < CH; c++) begin : g_dec
        wire [2:0] st = SMP_STATE_I[3*c +: 3];
        wire is_exp = (st == LS_EXP_HI) | (st == LS_EXP_LO);
        assign dec_val[c] = (st == LS_DRIVE_HI);
        // Compared lines are never driven, so the far side's answer is seen;
        // expected-only mode drives no stimulus at all
        assign dec_rel[c] = tri_pat[c] | (st == LS_TRI) | (st == LS_IGNORE) | is_exp |
                            ctrl_ff[CTRL_CMP_MODE];
        assign dec_exp[c] = (st == LS_EXP_HI);
        assign dec_chk[c] = is_exp;
    end

    // Compare against aligned acquisition
    wire [CH-1:0] miss = (acq_s2_ff ^ exp_val_ff[ALIGN-1]) & exp_en_ff[ALIGN-1];
    wire err_now = |miss;
    wire same_rep = flt_any_ff & (miss == flt_mask_ff) &
                    (exp_idx_ff[ALIGN-1] == flt_idx_ff + flt_cnt_ff);

    // Register write decode
    wire wr_ctrl = REG_WR_I & (REG_ADDR_I == REG_CTRL);
    wire wr_tri = REG_WR_I & (REG_ADDR_I == REG_TRI_DATA);

    // Configuration registers; software pulses self clear
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctrl_ff <= '0;
            data_dly_ff <= '0;
            clk_dly_ff <= '0;
            pos_rise_ff <= '1;
            pos_fall_ff <= '0;
            start_cfg_ff <= {2'b00, SRC_SW};
            pause_src_ff <= SRC_SW;
            script_cfg_ff <= {4{8'h0C}};
            route_ff <= '1;
            tri_addr_ff <= '0;
        end else if (CE_I) begin
            ctrl_ff[CTRL_SW_START] <= 1'b0;
            ctrl_ff[CTRL_SW_SCRIPT +: 4] <= 4'h0;
            if (wr_ctrl) ctrl_ff <= REG_WDATA_I;
            if (REG_WR_I) begin
                case (REG_ADDR_I)
                    // Delays clipped at one full period
                    REG_DATA_DLY: data_dly_ff <= (REG_WDATA_I[DLY_W-1:0] > DLY_FULL)
                                   ? DLY_FULL : REG_WDATA_I[DLY_W-1:0];
                    REG_CLK_DLY: clk_dly_ff <= (REG_WDATA_I[DLY_W-1:0] > DLY_FULL)
                                  ? DLY_FULL : REG_WDATA_I[DLY_W-1:0];
                    REG_POS_RISE: pos_rise_ff <= REG_WDATA_I[CH-1:0];
                    REG_POS_FALL: pos_fall_ff <= REG_WDATA_I[CH-1:0];
                    REG_START_CFG: start_cfg_ff <= REG_WDATA_I[5:0];
                    REG_PAUSE_CFG: pause_src_ff <= REG_WDATA_I[SRC_W-1:0];
                    REG_SCRIPT_CFG: script_cfg_ff <= REG_WDATA_I;
                    REG_ROUTE: route_ff <= REG_WDATA_I;
                    REG_TRI_ADDR: tri_addr_ff <= REG_WDATA_I[TRI_AW-1:0];
                    default: ;
                endcase
            end
        end
    end

    // Tristate memory, written through address and data pair
    always_ff @(posedge CLK_SYS_I) begin
        if (CE_I && wr_tri && (tri_addr_ff < TRI_AW'(TRI_DEPTH)))
            tri_mem[tri_addr_ff] <= REG_WDATA_I[CH-1:0];
    end

    // Engine, outputs and events, all aligned to data
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            gen_ff <= GS_IDLE;
            smp_cnt_ff <= '0;
            DATA_O <= '0;
            DATA_OE_N_O <= '1;
            MARKER_O <= '0;
            READY_O <= 1'b0;
            ACTIVE_O <= 1'b0;
            scr_prev_ff <= '0;
            scr_hit_ff <= '0;
        end else if (CE_I) begin
            gen_ff <= nxt_gen;
            scr_prev_ff <= scr_lvl;
            scr_hit_ff <= scr_trig;
            READY_O <= (nxt_gen == GS_READY);
            ACTIVE_O <= smp_take;
            MARKER_O <= smp_take ? SMP_MARKER_I : 4'h0;
            if (gen_ff == GS_READY && start_hit) smp_cnt_ff <= '0;
            if (smp_take) begin
                DATA_O <= dec_val;
                DATA_OE_N_O <= dec_rel;
                smp_cnt_ff <= smp_cnt_ff + 32'h1;
            end
        end
    end

    // Alignment line for expected values
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            for (int i = 0; i < ALIGN; i++) begin
                exp_val_ff[i] <= '0;
                exp_en_ff[i] <= '0;
                exp_idx_ff[i] <= '0;
            end
        end else if (CE_I) begin
            exp_val_ff[0] <= dec_exp;
            exp_en_ff[0] <= smp_take ? dec_chk : '0;
            exp_idx_ff[0] <= smp_cnt_ff;
            for (int i = 1; i < ALIGN; i++) begin
                exp_val_ff[i] <= exp_val_ff[i-1];
                exp_en_ff[i] <= exp_en_ff[i-1];
                exp_idx_ff[i] <= exp_idx_ff[i-1];
            end
        end
    end

    // Fault record and sample error event
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            flt_idx_ff <= '0;
            flt_mask_ff <= '0;
            flt_cnt_ff <= '0;
            flt_any_ff <= 1'b0;
            SAMPLE_ERR_O <= 1'b0;
        end else if (CE_I) begin
            SAMPLE_ERR_O <= err_now;
            if (err_now) begin
                flt_any_ff <= 1'b1;
                if (ctrl_ff[CTRL_FILTER] && same_rep) begin
                    flt_cnt_ff <= flt_cnt_ff + 32'h1;
                end else begin
                    flt_idx_ff <= exp_idx_ff[ALIGN-1];
                    flt_mask_ff <= miss;
                    flt_cnt_ff <= 32'h1;
                end
            end
        end
    end

    // Delay controls to the output timing cells
    assign DATA_DLY_O = data_dly_ff; // Shared by all delayed channels
    assign DATA_LATE_O = ~pos_rise_ff & ~pos_fall_ff; // Delayed position
    assign CLK_DLY_O = clk_dly_ff;
    assign CLK_OFS_O = ctrl_ff[CTRL_CLK_OFS];

    // Export routing: each nibble picks a destination
    wire [7:0] ev_src = {MARKER_O[2:0], ACTIVE_O, READY_O, scr_hit_ff[0],
                         pause_lvl, start_hit};
    logic [3:0] fp_o, fp_en;
    logic [6:0] tl_o, tl_en;
    always_comb begin
        fp_o = '0;
        fp_en = '0;
        tl_o = '0;
        tl_en = '0;
        for (int e = 0; e < 8; e++) begin
            logic [SRC_W-1:0] d;
            d = route_ff[4*e +: SRC_W];
            if (d < DST_LINE0) begin
                fp_o[d[1:0]] = ev_src[e];
                fp_en[d[1:0]] = 1'b1;
            end else if (d != DST_NONE && e != 4 && d < DST_LINE0 + 4'h7) begin
                tl_o[3'(d - DST_LINE0)] = ev_src[e]; // No active on lines
                tl_en[3'(d - DST_LINE0)] = 1'b1;
            end
        end
    end
    assign FUNCTION_PIN_O = fp_o;
    assign FUNCTION_PIN_OE_N_O = ~fp_en;
    assign CHASSIS_TRIGGER_LINE_O = tl_o;
    assign CHASSIS_TRIGGER_LINE_OE_N_O = ~tl_en;

    // Register read mux, data one cycle later
    logic [31:0] rd_mux;
    always_comb begin
        case (REG_ADDR_I)
            REG_CTRL: rd_mux = ctrl_ff;
            REG_STATUS: rd_mux = {29'h0, flt_any_ff, gen_ff == GS_ACTIVE,
                                  gen_ff == GS_READY};
            REG_DATA_DLY: rd_mux = 32'(data_dly_ff);
            REG_CLK_DLY: rd_mux = 32'(clk_dly_ff);
            REG_POS_RISE: rd_mux = 32'(pos_rise_ff);
            REG_POS_FALL: rd_mux = 32'(pos_fall_ff);
            REG_FLT_INDEX: rd_mux = flt_idx_ff;
            REG_FLT_MASK: rd_mux = 32'(flt_mask_ff);
            REG_FLT_COUNT: rd_mux = flt_cnt_ff;
            REG_SAMPLE_CNT: rd_mux = smp_cnt_ff;
            default: rd_mux = 32'h0;
        endcase
    end
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) REG_RDATA_O <= '0;
        else if (CE_I && REG_RD_I) REG_RDATA_O <= rd_mux;
    end

    // Checks
    a_ready_to_active: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (CE_I && gen_ff == GS_READY && start_hit) |=> gen_ff == GS_ACTIVE)
        else $error("start not taken");
    // A pause level seen while running must stop the sample flow
    a_pause_holds: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (CE_I && gen_ff == GS_ACTIVE && ctrl_ff[CTRL_RUN] && pause_lvl)
        |=> gen_ff == GS_PAUSED)
        else $error("pause not taken");
    a_err_event: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (CE_I && |miss) |=> SAMPLE_ERR_O)
        else $error("mismatch without event");
    a_fault_mask: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (CE_I && err_now && !ctrl_ff[CTRL_FILTER]) |=> flt_mask_ff == $past(miss))
        else $error("fault mask wrong");
    a_delay_bound: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        DATA_DLY_O <= DLY_FULL && CLK_DLY_O <= DLY_FULL)
        else $error("delay above one period");
    a_active_event: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (CE_I && smp_take) |=> ACTIVE_O)
        else $error("active event missing");
    c_start: cover property (@(posedge CLK_SYS_I) gen_ff == GS_READY ##1 gen_ff == GS_ACTIVE);
    c_pause: cover property (@(posedge CLK_SYS_I) gen_ff == GS_PAUSED);
    c_error: cover property (@(posedge CLK_SYS_I) SAMPLE_ERR_O);
    c_repeat: cover property (@(posedge CLK_SYS_I) err_now && ctrl_ff[CTRL_FILTER] && same_rep);
    c_script: cover property (@(posedge CLK_SYS_I) scr_hit_ff[0]);
endmodule

// [test_pgc_top.sv]
/*
 * Self-checking bench for the pattern generation and compare block.
 * Assumes pgc_pkg is compiled and the partner model is present.
 */
`timescale 1ns/1ps
module test_pgc_top;
    import pgc_pkg::*;
    localparam int CH = 20;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic sv = 1'b0;
    logic sr;
    logic [3*CH-1:0] st = '0;
    logic [TRI_AW-1:0] tidx = '0;
    logic [3:0] mk = 4'h0;
    logic [3:0] fpi = 4'h0;
    logic [3:0] fpo;
    logic [3:0] fpoe;
    logic [CH-1:0] dat;
    logic [CH-1:0] doe;
    logic [CH-1:0] late;
    logic [DLY_W-1:0] ddly;
    logic [DLY_W-1:0] cdly;
    logic cofs;
    logic rdy;
    logic act;
    logic [3:0] mko;
    logic serr;
    logic [CH-1:0] acq;
    logic [CH-1:0] resp = '1;
    logic [31:0] d;
    int fails = 0;
    int compares = 0;
    int rdy_cnt = 0;
    int pin_cnt = 0;
    int err_cnt = 0;

    // Clock and event counters
    always #5 clk = ~clk;
    always @(posedge clk) begin
        rdy_cnt <= rdy_cnt + (rdy === 1'b1);
        pin_cnt <= pin_cnt + (fpo[1] === 1'b1);
        err_cnt <= err_cnt + (serr === 1'b1);
    end

    pgc_top #(.CH(CH), .ALIGN(4)) dut (
        .CLK_SYS_I(clk), .ARST_N_I(arst_n), .CE_I(1'b1),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .SMP_VALID_I(sv), .SMP_READY_O(sr),
        .SMP_STATE_I(st), .SMP_TRI_IDX_I(tidx), .SMP_MARKER_I(mk),
        .FUNCTION_PIN_I(fpi), .CHASSIS_TRIGGER_LINE_I(8'h00),
        .FUNCTION_PIN_O(fpo), .FUNCTION_PIN_OE_N_O(fpoe),
        .CHASSIS_TRIGGER_LINE_O(), .CHASSIS_TRIGGER_LINE_OE_N_O(),
        .DATA_O(dat), .DATA_OE_N_O(doe), .DATA_LATE_O(late), .DATA_DLY_O(ddly),
        .ACQ_DATA_I(acq), .CLK_DLY_O(cdly), .CLK_OFS_O(cofs), .READY_O(rdy),
        .ACTIVE_O(act), .MARKER_O(mko), .SAMPLE_ERR_O(serr)
    );

    pgc_dut_model #(.CH(CH)) model (
        .clk_i(clk), .data_i(dat), .oe_n_i(doe), .resp_i(resp), .acq_o(acq)
    );

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // One sample; outputs checked after the taking edge
    task automatic send(input logic [3*CH-1:0] s, input logic [TRI_AW-1:0] ti,
                        input logic [3:0] m);
        @(posedge clk);
        st <= s;
        tidx <= ti;
        mk <= m;
        sv <= 1'b1;
        @(posedge clk);
        sv <= 1'b0;
        #1;
    endtask

    // Bounded wait on sample ready
    task automatic wait_sr(input logic v);
        int n;
        n = 0;
        while (sr !== v && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic t_reset;
        rd_reg(REG_POS_RISE);
        check(d & 32'h000FFFFF, 32'h000FFFFF);
        rd_reg(8'hFC);
        check(d, 32'h0);
        check(32'(doe), 32'h000FFFFF);
    endtask

    task automatic t_timing;
        // Above one period: must be clipped to a full period
        wr_reg(REG_DATA_DLY, 32'h1FF);
        wr_reg(REG_CLK_DLY, 32'h40);
        wr_reg(REG_CTRL, 32'h20);
        wr_reg(REG_POS_RISE, 32'h0000F);
        wr_reg(REG_POS_FALL, 32'h000F0);
        @(posedge clk);
        #1;
        check(32'(ddly), 32'h100);
        check(32'(cdly), 32'h40);
        check(32'(cofs), 32'h1);
        check(32'(late), 32'hFFF00);
    endtask

    task automatic t_start;
        wr_reg(REG_ROUTE, 32'hFFFF1FFF);
        wr_reg(REG_START_CFG, 32'h0);
        wr_reg(REG_CTRL, 32'h21);
        repeat (3) @(posedge clk);
        #1;
        // Ready stands while waiting for start: two edges seen so far
        check(32'(rdy_cnt), 32'h2);
        check(32'(pin_cnt), 32'h2);
        check(32'(fpoe), 32'hD);
        check(32'(sr), 32'h0);
        @(posedge clk);
        fpi <= 4'h1;
        wait_sr(1'b1);
        check(32'(sr), 32'h1);
    endtask

    task automatic t_samples;
        logic [3*CH-1:0] s;
        s = '0;
        s[2:0] = 3'b001;
        s[5:3] = 3'b010;
        wr_reg(REG_TRI_ADDR, 32'h0);
        wr_reg(REG_TRI_DATA, 32'h0);
        wr_reg(REG_TRI_ADDR, 32'h5);
        wr_reg(REG_TRI_DATA, 32'h4);
        send(s, 12'h000, 4'h5);
        check(32'(dat), 32'h1);
        check(32'(doe), 32'h2);
        check({27'h0, act, mko}, 32'h15);
        send({CH{3'b001}}, 12'h005, 4'h0);
        check(32'(doe), 32'h4);
        // Expected-only mode: drive states are not driven
        wr_reg(REG_CTRL, 32'h29);
        send({CH{3'b001}}, 12'h000, 4'h0);
        check(32'(doe), 32'h000FFFFF);
        wr_reg(REG_CTRL, 32'h21);
    endtask

    task automatic t_pause;
        int base;
        wr_reg(REG_CTRL, 32'h25);
        wait_sr(1'b0);
        check(32'(sr), 32'h0);
        wr_reg(REG_CTRL, 32'h21);
        wait_sr(1'b1);
        check(32'(sr), 32'h1);
        // Software script trigger 0 routed to function pin 1: one pulse
        wr_reg(REG_ROUTE, 32'hFFFFF1FF);
        base = pin_cnt;
        wr_reg(REG_CTRL, 32'h121);
        repeat (4) @(posedge clk);
        check(32'(pin_cnt - base), 32'h1);
    endtask

    task automatic t_compare;
        int base;
        resp <= '1;
        repeat (6) @(posedge clk);
        base = err_cnt;
        repeat (4) send({CH{3'b100}}, 12'h000, 4'h0);
        repeat (12) @(posedge clk);
        check(32'(err_cnt - base), 32'h0);
        resp <= ~20'h8;
        repeat (6) @(posedge clk);
        send({CH{3'b100}}, 12'h000, 4'h0);
        repeat (12) @(posedge clk);
        check(32'(err_cnt - base), 32'h1);
        rd_reg(REG_FLT_MASK);
        check(d, 32'h8);
        // Filter on: samples 8 and 9 repeat the fault of sample 7
        wr_reg(REG_CTRL, 32'h31);
        repeat (2) send({CH{3'b100}}, 12'h000, 4'h0);
        repeat (12) @(posedge clk);
        check(32'(err_cnt - base), 32'h3);
        rd_reg(REG_FLT_INDEX);
        check(d, 32'h7);
        rd_reg(REG_FLT_COUNT);
        check(d, 32'h3);
    endtask

    task automatic print_verdict;
        if (fails == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_timing();
        t_start();
        t_samples();
        t_pause();
        t_compare();
        print_verdict();
    end

    // Watchdog against a hang
    initial begin
        #200000;
        fails++;
        print_verdict();
    end
endmodule
